// *** verilog/wspe_regs.svh ***
// Purpose: Timing counts and detection levels of the wheel-speed pulse encoder.
// Assumes: The block clock runs at 100 MHz.
// Notes: Times keep their printed unit; cycle counts are derived from them.
`ifndef WSPE_REGS_SVH
`define WSPE_REGS_SVH

`define WSPE_CLK_MHZ 100
`define WSPE_CLK_HZ (`WSPE_CLK_MHZ * 1000000)

`define WSPE_PRE_US 30
`define WSPE_FWD_US 45
`define WSPE_REV_US 90
`define WSPE_HS_US 30
`define WSPE_STILL_US 1440
`define WSPE_STOP_MS 737

`define WSPE_UP_HZ 1000
`define WSPE_DOWN_HZ 950
`define WSPE_HYS_HZ (`WSPE_UP_HZ - `WSPE_DOWN_HZ)

`define WSPE_ON_PCT 60
`define WSPE_OFF_PCT 40

`define WSPE_PRE_CYC (`WSPE_PRE_US * `WSPE_CLK_MHZ)
`define WSPE_FWD_CYC (`WSPE_FWD_US * `WSPE_CLK_MHZ)
`define WSPE_REV_CYC (`WSPE_REV_US * `WSPE_CLK_MHZ)
`define WSPE_HS_CYC (`WSPE_HS_US * `WSPE_CLK_MHZ)
`define WSPE_STILL_CYC (`WSPE_STILL_US * `WSPE_CLK_MHZ)
`define WSPE_STOP_CYC (`WSPE_STOP_MS * 1000 * `WSPE_CLK_MHZ)
`define WSPE_UP_PERIOD_CYC (`WSPE_CLK_HZ / `WSPE_UP_HZ)
`define WSPE_DOWN_PERIOD_CYC (`WSPE_CLK_HZ / `WSPE_DOWN_HZ)

`endif

// *** verilog/wspe_pkg.sv ***
// Purpose: Types shared by the wheel-speed pulse encoder files.
// Assumes: Nothing beyond the header of timing constants.
// Notes: The pulse kind is also a port of the top module.
package wspe_pkg;

  typedef enum logic [1:0] {
    WSPE_KIND_FWD,
    WSPE_KIND_REV,
    WSPE_KIND_HS,
    WSPE_KIND_STILL
  } wspe_kind_t;

  typedef enum logic [1:0] {
    WSPE_ST_IDLE,
    WSPE_ST_PRE,
    WSPE_ST_PULSE
  } wspe_state_t;

endpackage : wspe_pkg

// *** verilog/wspe_detect.sv ***
// Purpose: Turns the processed magnetic signal into switching events.
// Assumes: Peak and valley come from upstream amplitude tracking, one sample per clock.
// Notes: Both crossings make an event; only the switch-on one marks a new magnetic cycle.
`timescale 1ns/1ns
`include "wspe_regs.svh"

module wspe_detect
  import wspe_pkg::*;
#(
  parameter int unsigned SIG_W = 12
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [SIG_W-1:0] i_sample,
  input wire logic [SIG_W-1:0] i_peak_max,
  input wire logic [SIG_W-1:0] i_peak_min,
  output logic o_switched_on,
  output logic o_event,
  output logic o_cycle_start
);

  initial begin
    if (SIG_W < 2 || SIG_W > 24) $error("wspe_detect: SIG_W must be 2 to 24");
  end

  // The product is widened so that a full-scale span times 100 cannot overflow.
  function automatic logic [SIG_W-1:0] level_at(input logic [SIG_W-1:0] lo, input logic [SIG_W-1:0] hi,
                                                input int unsigned pct);
    logic [SIG_W+7:0] span;
    span = (hi > lo) ? {8'h00, hi - lo} : '0;
    return lo + SIG_W'((span * (SIG_W + 8)'(pct)) / (SIG_W + 8)'(100));
  endfunction : level_at

  logic [SIG_W-1:0] on_level;
  logic [SIG_W-1:0] off_level;
  logic next_switched_on;
  logic next_event;

  always_comb begin
    on_level = level_at(i_peak_min, i_peak_max, `WSPE_ON_PCT);
    off_level = level_at(i_peak_min, i_peak_max, `WSPE_OFF_PCT);
    next_switched_on = o_switched_on;
    next_event = 1'b0;
    if (!o_switched_on && i_sample >= on_level) begin
      next_switched_on = 1'b1;
      next_event = 1'b1;
    end else if (o_switched_on && i_sample <= off_level) begin
      next_switched_on = 1'b0;
      next_event = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_switched_on <= 1'b0;
      o_event <= 1'b0;
    end else begin
      o_switched_on <= next_switched_on;
      o_event <= next_event;
    end
  end

  assign o_cycle_start = o_event && o_switched_on;

  a_detect_on_level: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (!o_switched_on && i_sample >= on_level) |=> (o_switched_on && o_event))
    else $error("switch-on crossing not detected");

  a_detect_off_level: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (o_switched_on && i_sample > off_level) |=> o_switched_on)
    else $error("switched off above the switch-off level");

endmodule : wspe_detect

// *** verilog/wspe_encoder.sv ***
// Purpose: Wheel-speed pulse encoder: one current pulse on the two-wire line per event.
// Assumes: Direction comes from upstream phase logic and is valid with each sample.
// Notes: o_high_current high means the supply draws its pulse current.
`timescale 1ns/1ns
`include "wspe_regs.svh"

// Operation
// - Every pulse is preceded by 30 us (25 to 36 us) of low current on the line.
// - Below the low-speed threshold a forward event gives a 45 us pulse and a reverse event a 90 us pulse.
// - Above the high-speed threshold every event gives a 30 us pulse whatever its direction.
// - Encoding turns to high speed when the rising magnetic frequency passes about 1000 Hz.
// - Encoding returns to low speed when the falling frequency drops below about 950 Hz.
// - While the target stands still a standstill pulse of 1440 us is sent.
// - Standstill pulses repeat every 737 ms for as long as no magnetic event occurs.
// - An event switches on at 60 percent and back at 40 percent of the signal span.
module wspe_encoder
  import wspe_pkg::*;
#(
  parameter int unsigned SIG_W = 12,
  parameter int unsigned PEND_W = 3,
  parameter int unsigned STILL_CYC = `WSPE_STILL_CYC,
  parameter int unsigned STOP_CYC = `WSPE_STOP_CYC,
  parameter int unsigned FWD_CYC = `WSPE_FWD_CYC,
  parameter int unsigned REV_CYC = `WSPE_REV_CYC,
  parameter int unsigned UP_PERIOD_CYC = `WSPE_UP_PERIOD_CYC,
  parameter int unsigned DOWN_PERIOD_CYC = `WSPE_DOWN_PERIOD_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [SIG_W-1:0] i_sample,
  input wire logic [SIG_W-1:0] i_peak_max,
  input wire logic [SIG_W-1:0] i_peak_min,
  input wire logic i_reverse,
  output logic o_high_current,
  output wspe_kind_t o_pulse_kind,
  output logic o_high_speed,
  output logic o_busy
);

  localparam int unsigned PRE_CYC = `WSPE_PRE_CYC;
  localparam int unsigned HS_CYC = `WSPE_HS_CYC;
  localparam int unsigned CNT_W = 18;
  localparam int unsigned PER_W = 18;
  localparam int unsigned STOP_W = 27;

  initial begin
    if (STILL_CYC >= 2 ** CNT_W || REV_CYC >= 2 ** CNT_W || FWD_CYC < 1 || STILL_CYC < 1)
      $error("wspe_encoder: pulse widths must fit the width counter");
    if (DOWN_PERIOD_CYC + 1 >= 2 ** PER_W || UP_PERIOD_CYC > DOWN_PERIOD_CYC)
      $error("wspe_encoder: speed thresholds out of range");
    if (STOP_CYC >= 2 ** STOP_W || STOP_CYC < 2) $error("wspe_encoder: standstill period out of range");
    if (PEND_W < 1 || PEND_W > 8) $error("wspe_encoder: PEND_W must be 1 to 8");
  end

  function automatic logic [CNT_W-1:0] width_of(input wspe_kind_t kind);
    unique case (kind)
      WSPE_KIND_FWD: return CNT_W'(FWD_CYC - 1);
      WSPE_KIND_REV: return CNT_W'(REV_CYC - 1);
      WSPE_KIND_HS: return CNT_W'(HS_CYC - 1);
      WSPE_KIND_STILL: return CNT_W'(STILL_CYC - 1);
    endcase
  endfunction : width_of

  logic mag_event;
  logic cycle_start;

  wspe_detect #(
    .SIG_W(SIG_W)
  ) u_detect (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_sample(i_sample),
    .i_peak_max(i_peak_max),
    .i_peak_min(i_peak_min),
    .o_switched_on(),
    .o_event(mag_event),
    .o_cycle_start(cycle_start)
  );

  // Speed mode: period of the magnetic cycle measured between switch-on events.
  logic [PER_W-1:0] period_cnt;
  logic [PER_W-1:0] next_period_cnt;
  logic next_high_speed;

  always_comb begin
    next_period_cnt = period_cnt;
    next_high_speed = o_high_speed;
    if (cycle_start) begin
      next_period_cnt = '0;
      if (!o_high_speed && period_cnt < PER_W'(UP_PERIOD_CYC)) next_high_speed = 1'b1;
      if (o_high_speed && period_cnt > PER_W'(DOWN_PERIOD_CYC)) next_high_speed = 1'b0;
    end else if (period_cnt <= PER_W'(DOWN_PERIOD_CYC)) begin
      next_period_cnt = period_cnt + 1'b1;
    end else begin
      // A cycle already longer than the downshift period means the wheel slowed.
      next_high_speed = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      period_cnt <= '1;
      o_high_speed <= 1'b0;
    end else begin
      period_cnt <= next_period_cnt;
      o_high_speed <= next_high_speed;
    end
  end

  // Standstill timer, restarted by every magnetic event and by each standstill pulse.
  logic [STOP_W-1:0] stop_cnt;
  logic [STOP_W-1:0] next_stop_cnt;
  logic still_due;

  always_comb begin
    still_due = !mag_event && stop_cnt == STOP_W'(STOP_CYC - 1);
    next_stop_cnt = stop_cnt + 1'b1;
    if (mag_event || still_due) next_stop_cnt = '0;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stop_cnt <= '0;
    end else begin
      stop_cnt <= next_stop_cnt;
    end
  end

  // Pulse sequencer. Events that arrive during a pulse wait in a counter; they keep
  // the direction of the newest one, a trade-off that avoids a per-event buffer.
  wspe_state_t state;
  wspe_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  wspe_kind_t next_kind;
  logic [PEND_W-1:0] pend;
  logic [PEND_W-1:0] next_pend;
  logic pend_rev;
  logic next_pend_rev;
  logic next_high_current;
  logic take;
  wspe_kind_t ev_kind;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_kind = o_pulse_kind;
    next_pend = pend;
    next_pend_rev = pend_rev;
    ev_kind = o_high_speed ? WSPE_KIND_HS : (pend_rev ? WSPE_KIND_REV : WSPE_KIND_FWD);
    if (mag_event) begin
      next_pend_rev = i_reverse;
      if (pend != '1) next_pend = pend + 1'b1;
    end
    take = 1'b0;
    unique case (state)
      WSPE_ST_IDLE: begin
        if (pend != '0) begin
          take = 1'b1;
        end else if (still_due) begin
          next_state = WSPE_ST_PRE;
          next_cnt = CNT_W'(PRE_CYC - 1);
          next_kind = WSPE_KIND_STILL;
        end
      end
      WSPE_ST_PRE: begin
        if (cnt == '0) begin
          next_state = WSPE_ST_PULSE;
          next_cnt = width_of(o_pulse_kind);
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      WSPE_ST_PULSE: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else if (pend != '0) begin
          take = 1'b1;
        end else begin
          next_state = WSPE_ST_IDLE;
        end
      end
      default: next_state = WSPE_ST_IDLE;
    endcase
    if (take) begin
      next_state = WSPE_ST_PRE;
      next_cnt = CNT_W'(PRE_CYC - 1);
      next_kind = ev_kind;
      if (!mag_event) next_pend = pend - 1'b1;
      else if (pend == '1) next_pend = pend - 1'b1;
      else next_pend = pend;
    end
    next_high_current = next_state == WSPE_ST_PULSE;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= WSPE_ST_IDLE;
      cnt <= '0;
      o_pulse_kind <= WSPE_KIND_FWD;
      pend <= '0;
      pend_rev <= 1'b0;
      o_high_current <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      o_pulse_kind <= next_kind;
      pend <= next_pend;
      pend_rev <= next_pend_rev;
      o_high_current <= next_high_current;
    end
  end

  assign o_busy = state != WSPE_ST_IDLE;

  // Helper counters of the current run of low and high line cycles.
  logic [STOP_W-1:0] low_run;
  logic [CNT_W:0] high_run;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      low_run <= '0;
      high_run <= '0;
    end else begin
      low_run <= o_high_current ? '0 : ((low_run == '1) ? low_run : low_run + 1'b1);
      high_run <= o_high_current ? high_run + 1'b1 : '0;
    end
  end

  sequence s_pulse_end;
    $fell(o_high_current);
  endsequence

  a_pre_low_time: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    $rose(o_high_current) |-> low_run >= STOP_W'(PRE_CYC))
    else $error("pulse started without the low interval");

  // In a back-to-back pair the kind register already names the next pulse when the line falls,
  // so the kind of the pulse that just ended is taken one cycle back.
  a_fwd_rev_width: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_pulse_end ##0 ($past(o_pulse_kind) inside {WSPE_KIND_FWD, WSPE_KIND_REV}) |->
      high_run == (CNT_W + 1)'($past(o_pulse_kind) == WSPE_KIND_FWD ? FWD_CYC : REV_CYC))
    else $error("low-speed pulse width wrong");

  a_hs_pulse_width: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_pulse_end ##0 ($past(o_pulse_kind) == WSPE_KIND_HS) |-> high_run == (CNT_W + 1)'(HS_CYC))
    else $error("high-speed pulse width wrong");

  a_hs_kind_mode: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (take && o_high_speed) |=> o_pulse_kind == WSPE_KIND_HS)
    else $error("direction pulse sent in high-speed mode");

  a_upshift_rule: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (cycle_start && period_cnt < PER_W'(UP_PERIOD_CYC)) |=> o_high_speed)
    else $error("no upshift on a fast cycle");

  a_downshift_rule: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (o_high_speed && period_cnt > PER_W'(DOWN_PERIOD_CYC)) |=> !o_high_speed)
    else $error("no downshift on a slow cycle");

  a_still_width: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_pulse_end ##0 ($past(o_pulse_kind) == WSPE_KIND_STILL) |-> high_run == (CNT_W + 1)'(STILL_CYC))
    else $error("standstill pulse width wrong");

  a_still_repeat: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (still_due && state == WSPE_ST_IDLE && pend == '0) |=> (state == WSPE_ST_PRE && o_pulse_kind == WSPE_KIND_STILL))
    else $error("standstill pulse not started when due");

  a_event_queued: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (mag_event && state == WSPE_ST_PRE && pend != '1) |=> pend == $past(pend) + 1'b1 ##0 stop_cnt == '0)
    else $error("event lost during a pulse");

endmodule : wspe_encoder

// *** bench/wspe_vcu_model.sv ***
// Purpose: Current-sensing input of the control unit that listens to the encoder line.
// Assumes: The line level is sampled on the block clock.
// Notes: Keeps the width of the last finished pulse and a count of pulses.
`timescale 1ns/1ns

module wspe_vcu_model (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_high_current,
  output logic [31:0] o_last_width,
  output logic [31:0] o_pulses
);
  logic [31:0] run;

  // A pulse counts only once it has ended, so one still in progress never shows here.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run <= '0;
      o_last_width <= '0;
      o_pulses <= '0;
    end else if (i_high_current) begin
      run <= run + 1;
    end else if (run != 0) begin
      o_last_width <= run;
      o_pulses <= o_pulses + 1;
      run <= '0;
    end
  end
endmodule : wspe_vcu_model

// *** bench/wspe_encoder_tb.sv ***
// Purpose: Self-checking bench of the wheel-speed pulse encoder.
// Assumes: Shortened counts for standstill, forward width and speed thresholds; the rest keep their real length.
// Notes: Peak 1000 and valley 100 put the switch levels at 640 and 460.
`timescale 1ns/1ns

module wspe_encoder_tb;
  import wspe_pkg::*;

  logic i_mclk;
  logic i_sys_rst;
  logic [11:0] i_sample;
  logic i_reverse;
  logic [11:0] peak_max;
  logic [11:0] peak_min;
  logic o_high_current;
  wspe_kind_t o_pulse_kind;
  logic o_high_speed;
  logic o_busy;
  logic [31:0] last_width;
  logic [31:0] pulses;
  int cyc;
  int t_start;
  int n_errors;
  int samples_checked;

  wspe_encoder #(.STILL_CYC(500), .STOP_CYC(20000), .FWD_CYC(450), .UP_PERIOD_CYC(2000),
    .DOWN_PERIOD_CYC(2200)) uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sample(i_sample),
    .i_peak_max(peak_max), .i_peak_min(peak_min), .i_reverse(i_reverse), .o_high_current(o_high_current),
    .o_pulse_kind(o_pulse_kind), .o_high_speed(o_high_speed), .o_busy(o_busy));

  wspe_vcu_model model (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_high_current(o_high_current),
    .o_last_width(last_width), .o_pulses(pulses));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic results();
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // The run needs about 96000 cycles, most of them the queue drain and two standstill periods.
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_errors++;
      $display("ERROR %0t: run did not finish", $time);
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick

  // Follows one pulse from the first low cycle of its pre-low interval to its last high cycle.
  task automatic wait_pulse(input wspe_kind_t kind, input int width);
    int n;
    n = 0;
    while (!(o_busy === 1'b1 && o_high_current === 1'b0) && n < 30000) begin
      tick(1);
      n++;
    end
    t_start = cyc;
    check(32'(o_pulse_kind), 32'(kind));
    n = 0;
    while (o_high_current !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    check(n, 3000);
    n = 0;
    while (o_high_current === 1'b1 && n < 10000) begin
      tick(1);
      n++;
    end
    check(n, width);
  endtask : wait_pulse

  task automatic sc_levels();
    i_sample = 12'h27f;
    tick(10);
    check(o_busy, 1'b0);
    i_sample = 12'h280;
    wait_pulse(WSPE_KIND_FWD, 450);
    i_sample = 12'h1cd;
    tick(10);
    check(o_busy, 1'b0);
    i_sample = 12'h1cc;
    i_reverse = 1'b1;
    wait_pulse(WSPE_KIND_REV, 9000);
  endtask : sc_levels

  task automatic sc_back_to_back();
    logic [31:0] p0;
    i_reverse = 1'b0;
    i_sample = 12'h2bc;
    tick(1);
    // The previous pulse is counted by the model at this edge; the second crossing follows at once.
    p0 = pulses;
    i_sample = 12'h12c;
    wait_pulse(WSPE_KIND_FWD, 450);
    wait_pulse(WSPE_KIND_FWD, 450);
    tick(5);
    check(pulses - p0, 2);
    check(o_busy, 1'b0);
  endtask : sc_back_to_back

  task automatic mag(input int n, input int period);
    repeat (n) begin
      i_sample = 12'h2bc;
      tick(period / 2);
      i_sample = 12'h12c;
      tick(period / 2);
    end
  endtask : mag

  task automatic sc_speed();
    mag(2, 1500);
    check(o_high_speed, 1'b1);
    mag(2, 2100);
    check(o_high_speed, 1'b1);
    check(32'(o_pulse_kind), 32'(WSPE_KIND_HS));
    tick(300);
    check(o_high_speed, 1'b0);
    tick(2200);
    check(last_width, 3000);
  endtask : sc_speed

  // Drains the queued pulses, then one fresh event restarts the standstill timer; the timer runs
  // from events, not from pulse starts, so the reference is the moment of that crossing.
  task automatic sc_standstill();
    int n;
    int last;
    int t1;
    n = 0;
    while (o_busy !== 1'b0 && n < 60000) begin
      tick(1);
      n++;
    end
    last = cyc;
    i_sample = 12'h2bc;
    wait_pulse(WSPE_KIND_FWD, 450);
    wait_pulse(WSPE_KIND_STILL, 500);
    check(32'((t_start - last) inside {[19998:20002]}), 1);
    t1 = t_start;
    wait_pulse(WSPE_KIND_STILL, 500);
    check(32'((t_start - t1) inside {[19998:20002]}), 1);
  endtask : sc_standstill

  initial begin
    cyc = 0;
    n_errors = 0;
    samples_checked = 0;
    i_sys_rst = 1'b1;
    i_sample = 12'h000;
    i_reverse = 1'b0;
    peak_max = 12'h03e8;
    peak_min = 12'h0064;
    tick(12);
    i_sys_rst = 1'b0;
    tick(2);
    sc_levels();
    sc_back_to_back();
    sc_speed();
    sc_standstill();
    results();
  end
endmodule : wspe_encoder_tb
